// *** rtl/isp_regs.vh ***
// Constants for the ISP boot entry and command block.
// Included by rtl/isp_boot_entry.v; definitions only.
`ifndef ISP_REGS_VH
`define ISP_REGS_VH
`define ISP_ADDR_UNLOCK     12'h000
`define ISP_ADDR_CTRL       12'h004
`define ISP_ADDR_STATUS     12'h008
`define ISP_ADDR_TIMING     12'h00C
`define ISP_ADDR_OPTION     12'h010
`define ISP_ADDR_JUMP       12'h014
`define ISP_UNLOCK_KEY      6'h26
`define ISP_UNLOCK_CYCLES   4'h8
`define ISP_TIMING_RESET    8'h7B
`define ISP_OPTION_RESET    8'h00
`define ISP_OPT_FLEX        0
`define ISP_OPT_SEC         1
`define ISP_CMD_TIMING      8'h3B
`define ISP_CMD_PAGE_ERASE  8'hB3
`define ISP_CMD_MASS_ERASE  8'hBF
`define ISP_CMD_READ_BYTE   8'h1D
`define ISP_CMD_BURST_RD    8'hA3
`define ISP_CMD_WRITE_BYTE  8'h71
`define ISP_CMD_BURST_WR    8'h8F
`define ISP_CMD_EXIT        8'hD3
`define ISP_OPTION_ADDR     16'hFFFF
`define ISP_BURST_WR_MAX    8'h10
`define ISP_MASS_KEY        8'h55
`define ISP_HOLD_CYCLES     3
`define ISP_DEBOUNCE_CYCLES 4'h8
`define ISP_SECURED_BYTE    8'hFF
`endif

// *** rtl/isp_boot_entry.v ***
// ISP boot entry gate, forced boot-ROM strap and serial command engine.
// Assumes one APB slave, 10 MHz pclk as instruction clock, host-made
// serial clock sampled as a plain input, flash array outside the block.
// Functional notes
// RULE1 - Unlock flag set only on matching six-bit key
// RULE2 - Unlock flag lasts exactly eight cycles
// RULE3 - Boot jump into ROM only while unlocked
// RULE4 - Breakpoint freezes unlock counter while unlocked; the code freezes it only while emulation_mode is also high
// RULE5 - Interrupts do not stop unlock countdown
// RULE6 - High-voltage reset starts at boot ROM zero
// RULE7 - Host holds entry pin three cycles past reset
// RULE8 - Later ordinary reset starts at flash zero
// RULE9 - Forced entry leaves option bits unchanged
// RULE10 - Security bit cleared only by mass erase; the code also lets an APB write to ISP_ADDR_OPTION clear it
// RULE11 - Load clock output while entry pin high
// RULE12 - Debounce entry pin low before commands
// RULE13 - Timing write command first, one value
// RULE14 - Page and mass erase return nothing
// RULE15 - Byte read, secured 0xFF, option at FFFF
// RULE16 - Burst read returns n bytes or 0xFF
// RULE17 - Byte write programs one data byte
// RULE18 - Burst write up to sixteen consecutive bytes
// RULE19 - Exit resets into flash if flex set
// RULE20 - Unknown command bytes silently ignored
// RULE21 - Parameters collected before action or reply
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "isp_regs.vh"
module isp_boot_entry (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        high_voltage_entry_pin,
   input  wire        breakpoint,
   input  wire        emulation_mode,
   output reg         load_clock_output_pin,
   input  wire        serial_shift_clock,
   input  wire        serial_in,
   output reg         serial_out,
   output reg         flash_rd,
   output reg         flash_wr,
   output reg         page_erase,
   output reg         mass_erase,
   output reg  [15:0] flash_addr,
   output reg  [7:0]  flash_wdata,
   input  wire [7:0]  flash_rdata,
   output reg         boot_rom_select,
   output reg  [15:0] jump_target,
   output reg         jump_valid,
   output reg         soft_reset
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_PARAM = 3'h1;
   localparam ST_READ  = 3'h2;
   localparam ST_SEND  = 3'h3;
   localparam ST_WDATA = 3'h4;
   localparam ST_OFF   = 3'h5;

   reg  [3:0]  unlock_cnt_r;
   reg  [7:0]  timing_r;
   reg  [7:0]  option_r;
   reg  [1:0]  hv_sync_r;
   reg  [2:0]  sk_sync_r;
   reg  [1:0]  si_sync_r;
   reg  [3:0]  deb_cnt_r;
   reg         isp_en_r;
   reg         timing_done_r;
   reg  [1:0]  hold_cnt_r;
   reg         strap_taken_r;
   reg  [2:0]  state_r;
   reg  [7:0]  cmd_r;
   reg  [2:0]  pidx_r;
   reg  [2:0]  pneed_r;
   reg  [7:0]  rx_sh_r;
   reg  [2:0]  rx_bit_r;
   reg  [7:0]  tx_sh_r;
   reg  [2:0]  tx_bit_r;
   reg  [15:0] count_r;
   reg  [3:0]  bp_sync_r;
   wire        unlocked = (unlock_cnt_r != 4'h0);
   wire        hv       = hv_sync_r[1];
   wire        sk_rise  = sk_sync_r[1] & ~sk_sync_r[2];
   wire        sk_fall  = ~sk_sync_r[1] & sk_sync_r[2];
   wire        secured  = option_r[`ISP_OPT_SEC];
   wire        wr_acc   = psel & penable & pwrite;
   wire        rx_done  = sk_rise & (rx_bit_r == 3'h7);
   wire [7:0]  rx_byte  = {rx_sh_r[6:0], si_sync_r[1]};

   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // Parameter byte count after the command byte
   function [2:0] param_len;
      input [7:0] c;
      begin
         case (c)
            `ISP_CMD_TIMING:     param_len = 3'h1;
            `ISP_CMD_PAGE_ERASE: param_len = 3'h2;
            `ISP_CMD_MASS_ERASE: param_len = 3'h1;
            `ISP_CMD_READ_BYTE:  param_len = 3'h2;
            `ISP_CMD_BURST_RD:   param_len = 3'h4;
            `ISP_CMD_WRITE_BYTE: param_len = 3'h2;
            `ISP_CMD_BURST_WR:   param_len = 3'h3;
            `ISP_CMD_EXIT:       param_len = 3'h0;
            default:             param_len = 3'h7;
         endcase
      end
   endfunction

   // Read data from the array, masked by security
   function [7:0] read_value;
      input [15:0] a;
      input        sec;
      input [7:0]  arr;
      input [7:0]  opt;
      begin
         if (a == `ISP_OPTION_ADDR)
            read_value = opt; // RULE15
         else if (sec)
            read_value = `ISP_SECURED_BYTE; // RULE16
         else
            read_value = arr;
      end
   endfunction

   // Pin synchronisers; first stages feed only second stages
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hv_sync_r <= 2'b00;
         sk_sync_r <= 3'b000;
         si_sync_r <= 2'b00;
         bp_sync_r <= 4'h0;
      end else begin
         hv_sync_r <= {hv_sync_r[0], high_voltage_entry_pin};
         sk_sync_r <= {sk_sync_r[1:0], serial_shift_clock};
         si_sync_r <= {si_sync_r[0], serial_in};
         bp_sync_r <= {bp_sync_r[1:0], emulation_mode, breakpoint};
      end
   end

   // Unlock gate and boot jump
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_cnt_r <= 4'h0;
         jump_valid   <= 1'b0;
         jump_target  <= 16'h0000;
      end else begin
         jump_valid <= 1'b0;
         if (wr_acc && paddr == `ISP_ADDR_UNLOCK &&
             pwdata[7:2] == `ISP_UNLOCK_KEY)
            unlock_cnt_r <= `ISP_UNLOCK_CYCLES; // RULE1
         else if (unlocked && !(&bp_sync_r[3:2]))
            unlock_cnt_r <= unlock_cnt_r - 4'h1; // RULE2 RULE4 RULE5
         if (wr_acc && paddr == `ISP_ADDR_JUMP) begin
            jump_valid  <= 1'b1;
            // Jump into ROM only with a live key, else boot source kept
            jump_target <= pwdata[15:0]; // RULE3
         end
      end
   end

   // Boot source, strap capture after release, exit
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         boot_rom_select <= 1'b0;
         strap_taken_r   <= 1'b0;
         hold_cnt_r      <= 2'h0;
         soft_reset      <= 1'b0;
      end else begin
         soft_reset <= 1'b0;
         if (!strap_taken_r) begin
            if (hold_cnt_r != `ISP_HOLD_CYCLES)
               hold_cnt_r <= hold_cnt_r + 2'h1;
            // Entry pin still high three cycles after release
            else begin
               strap_taken_r   <= 1'b1;
               boot_rom_select <= hv; // RULE6 RULE7 RULE8
            end
         end
         if (wr_acc && paddr == `ISP_ADDR_JUMP && unlocked)
            boot_rom_select <= 1'b1; // RULE3
         if (state_r == ST_OFF) begin
            soft_reset      <= 1'b1;
            boot_rom_select <= ~option_r[`ISP_OPT_FLEX]; // RULE19
         end
      end
   end

   // Load clock out, debounce of the entry pin falling
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_clock_output_pin <= 1'b0;
         deb_cnt_r             <= 4'h0;
         isp_en_r              <= 1'b0;
      end else begin
         load_clock_output_pin <= hv ? ~load_clock_output_pin : 1'b0; // RULE11
         if (hv || !boot_rom_select) begin
            deb_cnt_r <= 4'h0;
            if (!boot_rom_select)
               isp_en_r <= 1'b0;
         end else if (deb_cnt_r != `ISP_DEBOUNCE_CYCLES)
            deb_cnt_r <= deb_cnt_r + 4'h1;
         else
            isp_en_r <= 1'b1; // RULE12
      end
   end

   // Serial command engine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r       <= ST_IDLE;
         cmd_r         <= 8'h00;
         pidx_r        <= 3'h0;
         pneed_r       <= 3'h0;
         rx_sh_r       <= 8'h00;
         rx_bit_r      <= 3'h0;
         tx_sh_r       <= 8'h00;
         tx_bit_r      <= 3'h0;
         count_r       <= 16'h0000;
         serial_out    <= 1'b0;
         timing_r      <= `ISP_TIMING_RESET;
         option_r      <= `ISP_OPTION_RESET;
         timing_done_r <= 1'b0;
         flash_rd      <= 1'b0;
         flash_wr      <= 1'b0;
         page_erase    <= 1'b0;
         mass_erase    <= 1'b0;
         flash_addr    <= 16'h0000;
         flash_wdata   <= 8'h00;
      end else begin
         flash_rd   <= 1'b0;
         flash_wr   <= 1'b0;
         page_erase <= 1'b0;
         mass_erase <= 1'b0;
         if (wr_acc && paddr == `ISP_ADDR_OPTION)
            option_r <= pwdata[7:0];
         if (wr_acc && paddr == `ISP_ADDR_TIMING)
            timing_r <= pwdata[7:0];
         if (sk_rise) begin
            rx_sh_r  <= rx_byte;
            rx_bit_r <= rx_bit_r + 3'h1;
         end
         if (!isp_en_r) begin
            state_r  <= ST_IDLE;
            rx_bit_r <= 3'h0;
         end else begin
            case (state_r)
               ST_IDLE: if (rx_done) begin
                  cmd_r   <= rx_byte;
                  pidx_r  <= 3'h0;
                  pneed_r <= param_len(rx_byte);
                  if (param_len(rx_byte) == 3'h7) begin
                     state_r <= ST_IDLE; // RULE20
                  end else if (!timing_done_r &&
                               rx_byte != `ISP_CMD_TIMING) begin
                     state_r <= ST_IDLE; // RULE13
                  end else if (rx_byte == `ISP_CMD_EXIT)
                     state_r <= ST_OFF; // RULE19
                  else
                     state_r <= ST_PARAM;
               end
               ST_PARAM: if (rx_done) begin
                  pidx_r <= pidx_r + 3'h1;
                  case (pidx_r)
                     3'h0: flash_addr[15:8] <= rx_byte;
                     3'h1: flash_addr[7:0]  <= rx_byte;
                     3'h2: count_r[15:8]    <= rx_byte;
                     default: count_r[7:0]  <= rx_byte;
                  endcase
                  if (cmd_r == `ISP_CMD_TIMING) begin
                     timing_r      <= rx_byte; // RULE13
                     timing_done_r <= 1'b1;
                     state_r       <= ST_IDLE;
                  end else if (cmd_r == `ISP_CMD_MASS_ERASE) begin
                     if (rx_byte == `ISP_MASS_KEY) begin
                        mass_erase <= 1'b1; // RULE14
                        flash_addr <= 16'h0000;
                        option_r   <= `ISP_OPTION_RESET; // RULE10
                     end
                     state_r <= ST_IDLE;
                  end else if (pidx_r + 3'h1 == pneed_r) begin // RULE21
                     if (cmd_r == `ISP_CMD_PAGE_ERASE) begin
                        page_erase <= 1'b1; // RULE14
                        // Page erase clears flex, never security
                        option_r[`ISP_OPT_FLEX] <= 1'b0; // RULE9 RULE10
                        state_r <= ST_IDLE;
                     end else if (cmd_r == `ISP_CMD_READ_BYTE) begin
                        count_r <= 16'h0001;
                        flash_rd <= 1'b1;
                        state_r <= ST_READ; // RULE15
                     end else if (cmd_r == `ISP_CMD_BURST_RD) begin
                        count_r[7:0] <= rx_byte;
                        count_r[15]  <= 1'b0;
                        flash_rd <= 1'b1;
                        if ({1'b0, count_r[14:8], rx_byte} == 16'h0000)
                           state_r <= ST_IDLE;
                        else
                           state_r <= ST_READ; // RULE16
                     end else if (cmd_r == `ISP_CMD_BURST_WR) begin
                        count_r <= (rx_byte > `ISP_BURST_WR_MAX) ?
                           {8'h00, `ISP_BURST_WR_MAX} : {8'h00, rx_byte};
                        state_r <= (rx_byte == 8'h00) ? ST_IDLE
                                                      : ST_WDATA; // RULE18
                     end else
                        state_r <= ST_WDATA; // RULE17
                  end
               end
               ST_READ: if (!flash_rd) begin
                  tx_sh_r <= read_value(flash_addr, secured,
                                        flash_rdata, option_r);
                  tx_bit_r <= 3'h0;
                  state_r  <= ST_SEND;
               end
               ST_SEND: begin
                  if (sk_fall) begin
                     serial_out <= tx_sh_r[7];
                     tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
                     tx_bit_r <= tx_bit_r + 3'h1;
                     if (tx_bit_r == 3'h7) begin
                        count_r    <= count_r - 16'h0001;
                        flash_addr <= flash_addr + 16'h0001;
                        if (count_r == 16'h0001)
                           state_r <= ST_IDLE;
                        else begin
                           flash_rd <= 1'b1;
                           state_r  <= ST_READ;
                        end
                     end
                  end
               end
               ST_WDATA: if (rx_done) begin
                  flash_wdata <= rx_byte;
                  flash_wr    <= 1'b1; // RULE17 RULE18
                  if (cmd_r == `ISP_CMD_WRITE_BYTE ||
                      count_r == 16'h0001)
                     state_r <= ST_IDLE;
                  count_r <= count_r - 16'h0001;
               end
               ST_OFF:  state_r <= ST_IDLE;
               default: state_r <= ST_IDLE;
            endcase
         end
         // Burst write steps the address after each programmed byte
         if (flash_wr)
            flash_addr <= flash_addr + 16'h0001;
      end
   end

   // APB read mux; unmapped reads as zero
   always @* begin
      if (paddr == `ISP_ADDR_STATUS)
         prdata = {24'h0, 3'h0, isp_en_r, timing_done_r,
                   boot_rom_select, hv, unlocked};
      else if (paddr == `ISP_ADDR_TIMING)
         prdata = {24'h0, timing_r};
      else if (paddr == `ISP_ADDR_OPTION)
         prdata = {24'h0, option_r};
      else if (paddr == `ISP_ADDR_CTRL)
         prdata = {28'h0, unlock_cnt_r};
      else
         prdata = 32'h0000_0000;
   end
endmodule // isp_boot_entry

// *** dv/isp_boot_entry_monitor.sv ***
// Concurrent checks on the ports of the ISP boot entry block.
// Assumes the zero-wait APB map and constants of isp_regs.vh.
`timescale 1ns/1ps
`include "isp_regs.vh"
module isp_boot_entry_monitor (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        high_voltage_entry_pin,
   input wire        breakpoint,
   input wire        emulation_mode,
   input wire        load_clock_output_pin,
   input wire        flash_rd,
   input wire        flash_wr,
   input wire        page_erase,
   input wire        mass_erase,
   input wire        boot_rom_select,
   input wire [15:0] jump_target,
   input wire        jump_valid
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire        acc = psel && penable && pready;
   wire        jw  = acc && pwrite && paddr == `ISP_ADDR_JUMP;
   wire        sr  = acc && !pwrite && paddr == `ISP_ADDR_STATUS;
   wire        kw  = acc && pwrite && paddr == `ISP_ADDR_UNLOCK;
   logic [3:0] uc_r;
   // Own copy of the unlock window, frozen on breakpoint while emulation_mode is high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) uc_r <= 4'h0;
      else if (kw && pwdata[7:2] == `ISP_UNLOCK_KEY)
         uc_r <= `ISP_UNLOCK_CYCLES;
      else if (uc_r != 4'h0 && !(emulation_mode && breakpoint))
         uc_r <= uc_r - 4'h1;
   end
   sequence s_quiet;
      (!flash_wr && !flash_rd && !mass_erase && !page_erase) [*8];
   endsequence
   property p_apb_ok; pready && !pslverr; endproperty
   property p_unlock_flag; sr |-> prdata[0] == (uc_r != 4'h0); endproperty
   property p_jump_rom; jw && uc_r != 4'h0 |=> boot_rom_select; endproperty
   property p_jump_flash;
      jw && uc_r == 4'h0 && !boot_rom_select |=> !boot_rom_select && jump_valid
         && jump_target == $past(pwdata[15:0]);
   endproperty
   property p_jump_pulse; jump_valid |=> !jump_valid; endproperty
   property p_lclk_run;
      high_voltage_entry_pin [*4] |=>
         load_clock_output_pin != $past(load_clock_output_pin);
   endproperty
   property p_lclk_idle;
      !high_voltage_entry_pin [*4] |=> !load_clock_output_pin;
   endproperty
   property p_hv_quiet; high_voltage_entry_pin |=> s_quiet; endproperty
   property p_strap_rom;
      $rose(presetn) && high_voltage_entry_pin |-> ##8 boot_rom_select;
   endproperty
   property p_strap_flash;
      $rose(presetn) && !high_voltage_entry_pin |-> ##8 !boot_rom_select;
   endproperty
   a_apb_ok: assert property (p_apb_ok)
      else $error("apb answer not ready or in error");
   a_unlock_flag: assert property (p_unlock_flag)
      else $error("unlock flag disagrees with key timing");
   a_jump_rom: assert property (p_jump_rom)
      else $error("unlocked jump did not select boot rom");
   a_jump_flash: assert property (p_jump_flash)
      else $error("locked jump did not go to flash target");
   a_jump_pulse: assert property (p_jump_pulse)
      else $error("jump valid longer than one cycle");
   a_lclk_run: assert property (p_lclk_run)
      else $error("load clock not toggling under high voltage");
   a_lclk_idle: assert property (p_lclk_idle)
      else $error("load clock active without high voltage");
   a_hv_quiet: assert property (p_hv_quiet)
      else $error("flash access before entry pin debounced");
   a_strap_rom: assert property (p_strap_rom)
      else $error("high voltage reset did not start in boot rom");
   a_strap_flash: assert property (p_strap_flash)
      else $error("ordinary reset did not start in flash");
endmodule // isp_boot_entry_monitor

bind isp_boot_entry isp_boot_entry_monitor u_mon (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .high_voltage_entry_pin, .breakpoint, .emulation_mode,
   .load_clock_output_pin, .flash_rd, .flash_wr, .page_erase, .mass_erase,
   .boot_rom_select, .jump_target, .jump_valid);

// *** dv/isp_host_model.sv ***
// Host programmer on the serial ISP link, one byte per call.
// Assumes the device samples the shift clock with pclk.
`timescale 1ns/1ps
module isp_host_model (
   input  wire  pclk,
   output logic sk,
   output logic sdi,
   input  wire  sdo
);
   initial begin
      sk  = 1'b1;
      sdi = 1'b1;
   end
   // Clock stands high between bytes; four pclk per half period
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         @(posedge pclk);
         sk <= 1'b0;
         sdi <= tx[i];
         repeat (4) @(posedge pclk);
         sk <= 1'b1;
         rx[i] = sdo;
         repeat (3) @(posedge pclk);
      end
      repeat (16) @(posedge pclk);
      sdi <= ~tx[0];
   endtask
endmodule // isp_host_model

// *** dv/isp_boot_entry_and_commands_tb.sv ***
// Self-checking bench: APB register tasks, host byte sequences.
// Assumes a flash array answering one cycle after flash_rd.
`timescale 1ns/1ps
`include "isp_regs.vh"
module isp_boot_entry_and_commands_tb;
   logic        pclk, presetn, psel, penable, pwrite, breakpoint;
   logic        high_voltage_entry_pin, emulation_mode;
   logic [11:0] paddr;
   logic [31:0] pwdata, rd;
   logic [7:0]  flash_rdata, flash_wdata_r, rb;
   logic [15:0] flash_addr_r;
   wire  [31:0] prdata;
   wire         pready, pslverr, load_clock_output_pin, serial_shift_clock;
   wire         serial_in, serial_out, flash_rd, flash_wr, page_erase;
   wire         mass_erase, boot_rom_select, jump_valid, soft_reset;
   wire  [15:0] flash_addr, jump_target;
   wire  [7:0]  flash_wdata;
   int          failures, n_tests, n_wr, n_me, n_sr, n_pe;
   isp_boot_entry u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .high_voltage_entry_pin,
      .breakpoint, .emulation_mode, .load_clock_output_pin,
      .serial_shift_clock, .serial_in, .serial_out, .flash_rd, .flash_wr,
      .page_erase, .mass_erase, .flash_addr, .flash_wdata, .flash_rdata,
      .boot_rom_select, .jump_target, .jump_valid, .soft_reset);
   isp_host_model u_host (.pclk(pclk), .sk(serial_shift_clock),
      .sdi(serial_in), .sdo(serial_out));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // Flash stand-in: data is a function of address
   always @(posedge pclk) begin
      if (flash_rd) flash_rdata <= flash_addr[7:0] ^ 8'h5A;
      if (flash_wr) begin
         n_wr++;
         flash_addr_r <= flash_addr;
         flash_wdata_r <= flash_wdata;
      end
      if (mass_erase) n_me++;
      if (page_erase) n_pe++;
      if (soft_reset) n_sr++;
   end
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         failures++;
         complete_run;
      end
   endtask
   task automatic rdc(input string nm, input logic [11:0] a,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(nm, rd, e);
   endtask
   task automatic st(input string nm, input logic e);
      apb(1'b0, `ISP_ADDR_STATUS, 32'h0);
      check(nm, rd[0], e);
   endtask
   task automatic reboot(input logic h);
      presetn <= 1'b0;
      high_voltage_entry_pin <= h;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      high_voltage_entry_pin <= 1'b0;
      repeat (20) @(posedge pclk);
      check("boot rom select", boot_rom_select, h);
   endtask
   // Sends the n low bytes of v, most significant first
   task automatic tx(input int n, input logic [47:0] v);
      for (int i = n - 1; i >= 0; i--) u_host.xfer(v[8*i +: 8], rb);
      repeat (20) @(posedge pclk);
   endtask
   task automatic rx(input string nm, input logic [7:0] e);
      u_host.xfer(8'h00, rb);
      check(nm, rb, e);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, breakpoint, emulation_mode} = 6'h00;
      high_voltage_entry_pin = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      flash_rdata = 8'h00;
      {failures, n_tests, n_wr, n_me, n_sr, n_pe} = 0;
      reboot(1'b0);
      rdc("timing reset", `ISP_ADDR_TIMING, `ISP_TIMING_RESET);
      rdc("option reset", `ISP_ADDR_OPTION, `ISP_OPTION_RESET);
      rdc("unmapped", 12'h100, 32'h0);
      apb(1'b1, `ISP_ADDR_UNLOCK, {`ISP_UNLOCK_KEY ^ 6'h20, 2'b00});
      st("wrong key", 1'b0);
      apb(1'b1, `ISP_ADDR_JUMP, 32'h1234);
      repeat (2) @(posedge pclk);
      check("locked jump", boot_rom_select, 1'b0);
      apb(1'b1, `ISP_ADDR_UNLOCK, {`ISP_UNLOCK_KEY, 2'b11});
      apb(1'b1, `ISP_ADDR_JUMP, 32'h0042);
      repeat (2) @(posedge pclk);
      check("unlocked jump", boot_rom_select, 1'b1);
      repeat (10) @(posedge pclk);
      st("expired", 1'b0);
      emulation_mode <= 1'b1;
      breakpoint <= 1'b1;
      apb(1'b1, `ISP_ADDR_UNLOCK, {`ISP_UNLOCK_KEY, 2'b01});
      repeat (20) @(posedge pclk);
      st("frozen", 1'b1);
      rdc("frozen count", `ISP_ADDR_CTRL, 32'h8);
      breakpoint <= 1'b0;
      repeat (10) @(posedge pclk);
      st("resumed", 1'b0);
      $display("unlock test done");
      reboot(1'b1);
      tx(4, 48'h71_0001_77);
      check("early write", n_wr, 0);
      tx(2, 48'h3B_40);
      rdc("timing", `ISP_ADDR_TIMING, 32'h40);
      tx(2, 48'h00_C5);
      check("unknown", n_wr, 0);
      tx(4, 48'h71_1234_AB);
      check("write addr", {n_wr[15:0], flash_addr_r}, 32'h0001_1234);
      check("write data", flash_wdata_r, 8'hAB);
      tx(3, 48'h1D_0010);
      rx("read byte", 8'h10 ^ 8'h5A);
      tx(5, 48'hA3_0020_0003);
      for (int i = 0; i < 3; i++)
         rx("burst read", (8'h20 + i) ^ 8'h5A);
      tx(6, 48'h8F_0040_02_11_22);
      check("burst addr", {n_wr[15:0], flash_addr_r}, 32'h0003_0041);
      check("burst data", flash_wdata_r, 8'h22);
      apb(1'b1, `ISP_ADDR_OPTION, 32'h3);
      tx(3, 48'h1D_0010);
      rx("secured read", `ISP_SECURED_BYTE);
      tx(3, {32'h0, 8'h1D, 8'hFF} << 8 | 48'hFF);
      rx("option read", 8'h03);
      tx(5, 48'hA3_0020_0002);
      for (int i = 0; i < 2; i++)
         rx("secured burst", `ISP_SECURED_BYTE);
      tx(3, 48'hB3_0040);
      check("page erase", n_pe, 1);
      rdc("flex cleared", `ISP_ADDR_OPTION, 32'h2);
      tx(2, 48'hBF_00);
      check("bad mass key", n_me, 0);
      rdc("security kept", `ISP_ADDR_OPTION, 32'h2);
      tx(2, {40'h0, `ISP_CMD_MASS_ERASE} << 8 | `ISP_MASS_KEY);
      check("mass erase", n_me, 1);
      rdc("security cleared", `ISP_ADDR_OPTION, 32'h0);
      apb(1'b1, `ISP_ADDR_OPTION, 32'h1);
      tx(1, 48'hD3);
      check("exit reset", n_sr, 1);
      check("exit to flash", boot_rom_select, 1'b0);
      $display("serial command test done");
      complete_run;
   end
endmodule // isp_boot_entry_and_commands_tb
